// >>> hw/cif_pkg.sv
// shared constants and types of the can interrupt, transmit buffer and filter control block
package cif_pkg;

    // ====================================================================
    // register indices (byte address is four times the index)
    // ====================================================================
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_MODCTL = 10'h100;
    localparam logic [9:0] IDX_RXFLG = 10'h104;
    localparam logic [9:0] IDX_RXIE = 10'h105;
    localparam logic [9:0] IDX_TXFLG = 10'h106;
    localparam logic [9:0] IDX_TXCTL = 10'h107;
    localparam logic [9:0] IDX_ACCCTL = 10'h108;
    localparam logic [9:0] IDX_RXERR = 10'h10e;
    localparam logic [9:0] IDX_TXERR = 10'h10f;

    // ====================================================================
    // field positions
    // ====================================================================
    localparam int BIT_SOFTRST = 0;
    localparam int BIT_WAKE = 7;
    localparam int BIT_RXWARN = 6;
    localparam int BIT_TXWARN = 5;
    localparam int BIT_RXPASS = 4;
    localparam int BIT_TXPASS = 3;
    localparam int BIT_BUSOFF = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_RXFULL = 0;
    localparam int POS_ACK = 4;
    localparam int POS_TXE = 0;
    localparam int POS_ABORT = 4;
    localparam int POS_TXIE = 0;
    localparam int POS_MODE = 4;
    localparam int POS_HIT = 0;

    // ====================================================================
    // reset values and thresholds
    // ====================================================================
    localparam logic SOFTRST_RST = 1'b1;
    localparam logic [7:0] RXIE_RST = 8'h00;
    localparam logic [7:0] RXFLG_RST = 8'h00;
    localparam logic [2:0] TXE_RST = 3'h7;
    localparam logic [2:0] ACK_RST = 3'h0;
    localparam logic [2:0] ABORT_RST = 3'h0;
    localparam logic [2:0] TXIE_RST = 3'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] HIT_RST = 3'h0;
    localparam logic [7:0] WARN_LVL = 8'h60;
    localparam logic [7:0] PASSIVE_LVL = 8'h80;
    localparam logic [7:0] BUSOFF_RECOVER = 8'h80;

    typedef enum logic [1:0] {
        MODE_TWO32 = 2'b00,
        MODE_FOUR16 = 2'b01,
        MODE_EIGHT8 = 2'b10,
        MODE_CLOSED = 2'b11
    } cif_accmode_t;

endpackage : cif_pkg

// >>> hw/cif_accept_filter.sv
// identifier acceptance filter: byte compares, filter grouping, hit index
`timescale 1ns/1ps
module cif_accept_filter
(
    input wire logic [1:0] mode,
    input wire logic extId,
    input wire logic [31:0] ident,
    input wire logic [63:0] code,
    input wire logic [63:0] mask,
    output logic accept,
    output logic [2:0] hit
);

    logic [7:0] byteOk;
    logic [7:0] filtOk;

    // ====================================================================
    // per code byte compare against the identifier byte it faces
    // ====================================================================
    genvar k;
    generate
        for (k = 0; k < 8; k++)
        begin : g_byte
            logic [1:0] sel;
            always_comb
            begin
                if (mode == cif_pkg::MODE_TWO32)
                    sel = 2'(k % 4);
                else if (mode == cif_pkg::MODE_FOUR16)
                    sel = 2'(k % 2);
                else
                    sel = 2'h0;
            end
            // masked bits are ignored, the rest must match
            assign byteOk[k] = ((ident[8 * sel +: 8] ^ code[8 * k +: 8]) & ~mask[8 * k +: 8]) == 8'h00;
        end
    endgenerate

    // ====================================================================
    // filter grouping per mode, lowest filter wins
    // ====================================================================
    always_comb
    begin
        filtOk = 8'h00;
        accept = 1'b0;
        hit = 3'h0;
        case (cif_pkg::cif_accmode_t'(mode))
            cif_pkg::MODE_TWO32:
            begin
                // standard identifiers use only the first two bytes
                filtOk[0] = byteOk[0] & byteOk[1] & (~extId | (byteOk[2] & byteOk[3]));
                filtOk[1] = byteOk[4] & byteOk[5] & (~extId | (byteOk[6] & byteOk[7]));
            end
            cif_pkg::MODE_FOUR16:
            begin
                filtOk[0] = byteOk[0] & byteOk[1];
                filtOk[1] = byteOk[2] & byteOk[3];
                filtOk[2] = byteOk[4] & byteOk[5];
                filtOk[3] = byteOk[6] & byteOk[7];
            end
            cif_pkg::MODE_EIGHT8:
                filtOk = byteOk;
            default:
                filtOk = 8'h00;
        endcase
        for (int i = 7; i >= 0; i--)
        begin
            if (filtOk[i])
            begin
                accept = 1'b1;
                hit = 3'(i);
            end
        end
    end

endmodule : cif_accept_filter

// >>> hw/cif_ctrl.sv
// can control block: interrupt enables, transmit buffer handshake, acceptance control, error counter copies
//
// Overview of operation
// - wake-up flag reaches the wake interrupt only when its enable is set
// - six error-type flags each gated by own enable onto one error interrupt
// - accepted message filling receive buffer raises receive interrupt when enabled
// - interrupt enables, transmit flags and transmit control held reset during soft reset
// - abort acks read-only; empty flags cleared by writing one; reset restores register
// - clearing an empty flag also clears the same buffer's abort ack
// - empty flag set on successful send or granted abort; pends transmit interrupt
// - abort granted if not started or unsuccessful; sets empty and ack flags
// - software cannot clear abort request; it clears when the empty flag sets
// - each buffer has its own empty interrupt enable onto transmit interrupt
// - transmit control bits 7 and 3 read zero; aborts 6..4, enables 2..0
// - mode field selects two 32-bit, four 16-bit, eight 8-bit filters or closed
// - closed filter accepts nothing, foreground buffer never reloaded
// - read-only hit index names accepting filter, updated on foreground load
// - acceptance control writes only take effect while soft reset is set
// - two read-only byte registers show receive and transmit error counts, reset zero
// - every message lands in background; only accepted ones signal the cpu
// - bitwise masked compare on up to four ident bytes; standard ids use first two
// - warning flag set when count at least 96 with no passive or bus-off flag
// - bus-off set when transmit count passes 255; clear needs 128 recessive runs
`timescale 1ns/1ps
module cif_ctrl
#(
    parameter int NBUF = 3
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cif_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wakeEvent,
    input wire logic overrunEvent,
    input wire logic [7:0] rxErrCount,
    input wire logic [8:0] txErrCount,
    input wire logic recessiveRun,
    input wire logic rxMsgDone,
    input wire logic rxExtId,
    input wire logic [31:0] rxIdent,
    input wire logic [63:0] acceptCode,
    input wire logic [63:0] acceptMask,
    input wire logic [NBUF-1:0] txSentOk,
    input wire logic [NBUF-1:0] txAbortable,
    output logic [NBUF-1:0] txScheduled,
    output logic [NBUF-1:0] txAbortReq,
    output logic fgLoad,
    output logic softReset,
    output logic wakeIrq,
    output logic errIrq,
    output logic rxIrq,
    output logic txIrq
);

    logic softRst_q;
    logic [7:0] rxIe_q;
    logic [7:0] rxFlg_q;
    logic [7:0] rxFlgSet;
    logic [NBUF-1:0] txEmpty_q;
    logic [NBUF-1:0] abortAck_q;
    logic [NBUF-1:0] abortReq_q;
    logic [NBUF-1:0] txIe_q;
    logic [1:0] accMode_q;
    logic [2:0] hit_q;
    logic [7:0] rxErr_q;
    logic [7:0] txErr_q;
    logic [7:0] recov_q;
    logic fgLoad_q;
    logic wakeIrq_q;
    logic errIrq_q;
    logic rxIrq_q;
    logic txIrq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [9:0] idx;
    logic accessCyc;
    logic wrEn;
    logic mapped;
    logic [31:0] rdData;
    logic filtAccept;
    logic [2:0] filtHit;
    logic busOffRecovered;

    // ====================================================================
    // apb slave: one wait state, write and read data at the pready edge
    // ====================================================================
    assign idx = paddr[cif_pkg::ADDR_W-1:2];
    assign accessCyc = psel & penable & ~pready_q;
    assign wrEn = psel & penable & pready_q & pwrite & ~pslverr_q;

    always_comb
    begin
        mapped = 1'b1;
        rdData = 32'h0000_0000;
        if (idx == cif_pkg::IDX_MODCTL)
            rdData[cif_pkg::BIT_SOFTRST] = softRst_q;
        else if (idx == cif_pkg::IDX_RXFLG)
            rdData[7:0] = rxFlg_q;
        else if (idx == cif_pkg::IDX_RXIE)
            rdData[7:0] = rxIe_q;
        else if (idx == cif_pkg::IDX_TXFLG)
            rdData[7:0] = {1'b0, abortAck_q, 1'b0, txEmpty_q};
        else if (idx == cif_pkg::IDX_TXCTL)
            rdData[7:0] = {1'b0, abortReq_q, 1'b0, txIe_q};
        else if (idx == cif_pkg::IDX_ACCCTL)
            rdData[7:0] = {2'b00, accMode_q, 1'b0, hit_q};
        else if (idx == cif_pkg::IDX_RXERR)
            rdData[7:0] = rxErr_q;
        else if (idx == cif_pkg::IDX_TXERR)
            rdData[7:0] = txErr_q;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= accessCyc;
            pslverr_q <= accessCyc & ~mapped;
            if (accessCyc)
                prdata_q <= (pwrite || !mapped) ? 32'h0000_0000 : rdData;
        end
    end

    // ====================================================================
    // module control: soft reset bit
    // ====================================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            softRst_q <= cif_pkg::SOFTRST_RST;
        else if (wrEn && idx == cif_pkg::IDX_MODCTL)
            softRst_q <= pwdata[cif_pkg::BIT_SOFTRST];
    end

    // ====================================================================
    // receive interrupt enables
    // ====================================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rxIe_q <= cif_pkg::RXIE_RST;
        else if (softRst_q)
            rxIe_q <= cif_pkg::RXIE_RST;
        else if (wrEn && idx == cif_pkg::IDX_RXIE)
            rxIe_q <= pwdata[7:0];
    end

    // ====================================================================
    // receive and error flags, set wins over write-one clear
    // ====================================================================
    always_comb
    begin
        rxFlgSet = 8'h00;
        rxFlgSet[cif_pkg::BIT_WAKE] = wakeEvent;
        rxFlgSet[cif_pkg::BIT_RXWARN] = rxErrCount >= cif_pkg::WARN_LVL && rxErrCount < cif_pkg::PASSIVE_LVL
            && !rxFlg_q[cif_pkg::BIT_RXPASS] && !rxFlg_q[cif_pkg::BIT_TXPASS] && !rxFlg_q[cif_pkg::BIT_BUSOFF];
        rxFlgSet[cif_pkg::BIT_TXWARN] = txErrCount >= 9'(cif_pkg::WARN_LVL) && txErrCount < 9'(cif_pkg::PASSIVE_LVL)
            && !rxFlg_q[cif_pkg::BIT_RXPASS] && !rxFlg_q[cif_pkg::BIT_TXPASS] && !rxFlg_q[cif_pkg::BIT_BUSOFF];
        rxFlgSet[cif_pkg::BIT_RXPASS] = rxErrCount >= cif_pkg::PASSIVE_LVL && !rxFlg_q[cif_pkg::BIT_BUSOFF];
        rxFlgSet[cif_pkg::BIT_TXPASS] = txErrCount >= 9'(cif_pkg::PASSIVE_LVL) && !txErrCount[8]
            && !rxFlg_q[cif_pkg::BIT_BUSOFF];
        rxFlgSet[cif_pkg::BIT_BUSOFF] = txErrCount[8];
        rxFlgSet[cif_pkg::BIT_OVERRUN] = overrunEvent | (rxMsgDone & filtAccept & rxFlg_q[cif_pkg::BIT_RXFULL]);
        rxFlgSet[cif_pkg::BIT_RXFULL] = rxMsgDone & filtAccept & ~rxFlg_q[cif_pkg::BIT_RXFULL];
    end

    assign busOffRecovered = recov_q >= cif_pkg::BUSOFF_RECOVER;

    genvar f;
    generate
        for (f = 0; f < 8; f++)
        begin : g_rxflag
            logic clr;
            // bus-off stays until enough recessive runs were seen
            assign clr = wrEn && idx == cif_pkg::IDX_RXFLG && pwdata[f]
                && (f != cif_pkg::BIT_BUSOFF || busOffRecovered);
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    rxFlg_q[f] <= cif_pkg::RXFLG_RST[f];
                else if (softRst_q)
                    rxFlg_q[f] <= cif_pkg::RXFLG_RST[f];
                else if (rxFlgSet[f])
                    rxFlg_q[f] <= 1'b1;
                else if (clr)
                    rxFlg_q[f] <= 1'b0;
            end
        end
    endgenerate

    // counts runs of eleven recessive bits while bus-off
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            recov_q <= 8'h00;
        else if (softRst_q || !rxFlg_q[cif_pkg::BIT_BUSOFF])
            recov_q <= 8'h00;
        else if (recessiveRun && !busOffRecovered)
            recov_q <= recov_q + 8'h01;
    end

    // ====================================================================
    // acceptance control, hit index and foreground load
    // ====================================================================
    cif_accept_filter cif_accept_filter_i
    (
        .mode(accMode_q),
        .extId(rxExtId),
        .ident(rxIdent),
        .code(acceptCode),
        .mask(acceptMask),
        .accept(filtAccept),
        .hit(filtHit)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            accMode_q <= cif_pkg::MODE_RST;
        else if (wrEn && idx == cif_pkg::IDX_ACCCTL && softRst_q)
            accMode_q <= pwdata[cif_pkg::POS_MODE +: 2];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            hit_q <= cif_pkg::HIT_RST;
            fgLoad_q <= 1'b0;
        end
        else
        begin
            fgLoad_q <= rxFlgSet[cif_pkg::BIT_RXFULL] & ~softRst_q;
            if (rxFlgSet[cif_pkg::BIT_RXFULL] && !softRst_q)
                hit_q <= filtHit;
        end
    end

    // ====================================================================
    // error counter copies
    // ====================================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rxErr_q <= 8'h00;
            txErr_q <= 8'h00;
        end
        else
        begin
            rxErr_q <= rxErrCount;
            txErr_q <= txErrCount[8] ? 8'hff : txErrCount[7:0];
        end
    end

    // ====================================================================
    // transmit buffers: empty flag, abort ack, abort request, enable
    // ====================================================================
    genvar b;
    generate
        for (b = 0; b < NBUF; b++)
        begin : g_txbuf
            logic grant;
            logic setEmpty;
            logic swClr;
            assign grant = abortReq_q[b] & ~txEmpty_q[b] & txAbortable[b] & ~txSentOk[b];
            assign setEmpty = (txSentOk[b] & ~txEmpty_q[b]) | grant;
            assign swClr = wrEn && idx == cif_pkg::IDX_TXFLG && pwdata[cif_pkg::POS_TXE + b];
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    txEmpty_q[b] <= cif_pkg::TXE_RST[b];
                    abortAck_q[b] <= cif_pkg::ACK_RST[b];
                end
                else if (softRst_q)
                begin
                    txEmpty_q[b] <= cif_pkg::TXE_RST[b];
                    abortAck_q[b] <= cif_pkg::ACK_RST[b];
                end
                else if (setEmpty)
                begin
                    txEmpty_q[b] <= 1'b1;
                    abortAck_q[b] <= grant;
                end
                else if (swClr)
                begin
                    txEmpty_q[b] <= 1'b0;
                    abortAck_q[b] <= 1'b0;
                end
            end
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    abortReq_q[b] <= cif_pkg::ABORT_RST[b];
                else if (softRst_q)
                    abortReq_q[b] <= cif_pkg::ABORT_RST[b];
                else if (setEmpty || txEmpty_q[b])
                    abortReq_q[b] <= 1'b0;
                else if (wrEn && idx == cif_pkg::IDX_TXCTL && pwdata[cif_pkg::POS_ABORT + b])
                    abortReq_q[b] <= 1'b1;
            end
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    txIe_q[b] <= cif_pkg::TXIE_RST[b];
                else if (softRst_q)
                    txIe_q[b] <= cif_pkg::TXIE_RST[b];
                else if (wrEn && idx == cif_pkg::IDX_TXCTL)
                    txIe_q[b] <= pwdata[cif_pkg::POS_TXIE + b];
            end
        end
    endgenerate

    // ====================================================================
    // interrupt outputs
    // ====================================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wakeIrq_q <= 1'b0;
            errIrq_q <= 1'b0;
            rxIrq_q <= 1'b0;
            txIrq_q <= 1'b0;
        end
        else
        begin
            wakeIrq_q <= rxFlg_q[cif_pkg::BIT_WAKE] & rxIe_q[cif_pkg::BIT_WAKE];
            errIrq_q <= |(rxFlg_q[6:1] & rxIe_q[6:1]);
            rxIrq_q <= rxFlg_q[cif_pkg::BIT_RXFULL] & rxIe_q[cif_pkg::BIT_RXFULL];
            txIrq_q <= |(txEmpty_q & txIe_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign txScheduled = ~txEmpty_q;
    assign txAbortReq = abortReq_q;
    assign fgLoad = fgLoad_q;
    assign softReset = softRst_q;
    assign wakeIrq = wakeIrq_q;
    assign errIrq = errIrq_q;
    assign rxIrq = rxIrq_q;
    assign txIrq = txIrq_q;

    // ====================================================================
    // assertions
    // ====================================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sent_sets_empty_a: assert property ((!softRst_q && txSentOk[1] && !txEmpty_q[1]) |=> txEmpty_q[1])
        else $error("buffer 1 not empty after successful send");
    abort_cleared_a: assert property (txEmpty_q[1] |-> !abortReq_q[1])
        else $error("abort request left pending on empty buffer");
    ack_needs_empty_a: assert property ((abortAck_q & ~txEmpty_q) == 3'h0)
        else $error("abort ack without empty flag");
    soft_hold_a: assert property (softRst_q |=> (rxIe_q == 8'h00 && txIe_q == 3'h0
        && abortReq_q == 3'h0 && txEmpty_q == 3'h7))
        else $error("registers not held in soft reset");
    acc_lock_a: assert property ((wrEn && idx == cif_pkg::IDX_ACCCTL && !softRst_q)
        |=> $stable(accMode_q))
        else $error("acceptance mode written outside soft reset");
    tx_irq_a: assert property ((|(txEmpty_q & txIe_q)) |=> txIrq_q)
        else $error("transmit interrupt missing");
    closed_no_load_a: assert property ((accMode_q == cif_pkg::MODE_CLOSED && rxMsgDone) |=> !fgLoad_q)
        else $error("closed filter loaded foreground buffer");
    busoff_hold_a: assert property ((rxFlg_q[cif_pkg::BIT_BUSOFF] && !busOffRecovered && !softRst_q)
        |=> rxFlg_q[cif_pkg::BIT_BUSOFF])
        else $error("bus-off cleared before recovery");
    ack_clear_a: assert property ((!softRst_q && txEmpty_q[0] && !txSentOk[0] && wrEn
        && idx == cif_pkg::IDX_TXFLG && pwdata[0]) |=> !txEmpty_q[0] && !abortAck_q[0])
        else $error("ack not cleared with empty flag");
    err_irq_a: assert property ((rxFlg_q[cif_pkg::BIT_OVERRUN] && !rxIe_q[cif_pkg::BIT_OVERRUN]
        && (rxFlg_q[6:2] & rxIe_q[6:2]) == 5'h00) |=> !errIrq_q)
        else $error("masked overrun raised error interrupt");
    apb_answer_a: assert property ((psel && penable && !pready_q) |=> pready_q)
        else $error("apb answer late");

endmodule : cif_ctrl

// >>> bench/cif_can_side.sv
// far-side model of the can bit engine: transmit outcome per buffer
`timescale 1ns/1ps
module cif_can_side
(
    input wire logic ref_clk,
    input wire logic [2:0] txScheduled,
    input wire logic [2:0] started,
    input wire logic [2:0] sendGo,
    output logic [2:0] txSentOk,
    output logic [2:0] txAbortable
);
    // abortable while handed over and until a frame starts
    assign txAbortable = txScheduled & ~started;
    always_ff @(posedge ref_clk)
    begin
        // only a buffer handed over can complete a send
        txSentOk <= sendGo & txScheduled;
    end
endmodule : cif_can_side

// >>> bench/cif_ctrl_tb.sv
// self-checking bench of the can control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module cif_ctrl_tb;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rxIdent = 32'h0;
    logic wakeEvent = 1'b0, overrunEvent = 1'b0, recessiveRun = 1'b0, rxMsgDone = 1'b0, rxExtId = 1'b0;
    logic [7:0] rxErrCount = 8'h00;
    logic [8:0] txErrCount = 9'h000;
    logic [63:0] acceptCode = 64'h0, acceptMask = {64{1'b1}};
    logic [2:0] txSentOk, txAbortable, txScheduled, txAbortReq, started = 3'h0, sendGo = 3'h0;
    logic fgLoad, softReset, wakeIrq, errIrq, rxIrq, txIrq;
    logic [9:0] q[$];
    logic [9:0] e;
    logic [7:0] rx_full_flag;
    int n_mismatch = 0, comparisons = 0;
    int unsigned seed;
    cif_ctrl cif_ctrl_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .wakeEvent, .overrunEvent, .rxErrCount, .txErrCount, .recessiveRun, .rxMsgDone, .rxExtId,
        .rxIdent, .acceptCode, .acceptMask, .txSentOk, .txAbortable, .txScheduled, .txAbortReq, .fgLoad,
        .softReset, .wakeIrq, .errIrq, .rxIrq, .txIrq);
    cif_can_side cif_can_side_i (.ref_clk, .txScheduled, .started, .sendGo, .txSentOk, .txAbortable);
    always #2.5 ref_clk = ~ref_clk;
    // one apb transfer; expectation {write, slverr, data} noted first
    task bus(input logic w, input logic [9:0] ix, input logic [7:0] d, input logic er);
        q.push_back({w, er, d});
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    always @(posedge ref_clk)
    begin
        if (pready === 1'b1)
        begin
            e = q.pop_front();
            if (e[9] === 1'b0) `CHK("prdata", {24'h0, e[7:0]}, prdata)
            `CHK("pslverr", e[8], pslverr)
        end
    end
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        seed = $urandom(3);
        rxErrCount <= 8'($urandom);
        rxIdent <= $urandom;
        acceptCode <= {$urandom, $urandom};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // error flags that the random receive count will set
        rx_full_flag = rxErrCount >= cif_pkg::PASSIVE_LVL ? 8'h10 : (rxErrCount >= cif_pkg::WARN_LVL ? 8'h40 : 8'h00);
        `CHK("softReset", 1'b1, softReset)
        bus(0, cif_pkg::IDX_MODCTL, 8'h01, 0);
        bus(0, cif_pkg::IDX_TXFLG, 8'h07, 0);
        bus(0, cif_pkg::IDX_RXERR, rxErrCount, 0);
        bus(0, cif_pkg::IDX_TXERR, 8'h00, 0);
        bus(0, 10'h101, 8'h00, 1);
        bus(1, cif_pkg::IDX_RXIE, 8'hff, 0);
        bus(1, cif_pkg::IDX_TXCTL, 8'h77, 0);
        bus(0, cif_pkg::IDX_RXIE, 8'h00, 0);
        bus(0, cif_pkg::IDX_TXCTL, 8'h00, 0);
        for (int m = 0; m < 4; m++)
        begin
            bus(1, cif_pkg::IDX_ACCCTL, {2'h0, 2'(m), 4'h0}, 0);
            bus(0, cif_pkg::IDX_ACCCTL, {2'h0, 2'(m), 4'h0}, 0);
        end
        bus(1, cif_pkg::IDX_MODCTL, 8'h00, 0);
        bus(1, cif_pkg::IDX_ACCCTL, 8'h00, 0);
        bus(0, cif_pkg::IDX_ACCCTL, 8'h30, 0);
        $display("test registers done");
        bus(1, cif_pkg::IDX_RXIE, 8'h81, 0);
        wakeEvent <= 1'b1;
        overrunEvent <= 1'b1;
        rxMsgDone <= 1'b1;
        @(posedge ref_clk);
        wakeEvent <= 1'b0;
        overrunEvent <= 1'b0;
        rxMsgDone <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("wakeIrq", 1'b1, wakeIrq)
        `CHK("errIrq", 1'b0, errIrq)
        `CHK("rxIrq", 1'b0, rxIrq)
        bus(1, cif_pkg::IDX_RXIE, 8'h02, 0);
        repeat (3) @(posedge ref_clk);
        `CHK("errIrq", 1'b1, errIrq)
        `CHK("wakeIrq", 1'b0, wakeIrq)
        bus(0, cif_pkg::IDX_RXFLG, rx_full_flag | 8'h82, 0);
        $display("test events done");
        started <= 3'b010;
        bus(1, cif_pkg::IDX_TXFLG, 8'h03, 0);
        bus(1, cif_pkg::IDX_TXCTL, 8'h37, 0);
        bus(0, cif_pkg::IDX_TXFLG, 8'h15, 0);
        bus(0, cif_pkg::IDX_TXCTL, 8'h27, 0);
        `CHK("txAbortReq", 3'b010, txAbortReq)
        `CHK("txIrq", 1'b1, txIrq)
        sendGo <= 3'b010;
        @(posedge ref_clk);
        sendGo <= 3'b000;
        bus(0, cif_pkg::IDX_TXFLG, 8'h17, 0);
        bus(0, cif_pkg::IDX_TXCTL, 8'h07, 0);
        bus(1, cif_pkg::IDX_TXFLG, 8'h01, 0);
        bus(0, cif_pkg::IDX_TXFLG, 8'h06, 0);
        `CHK("txScheduled", 3'b001, txScheduled)
        $display("test transmit done");
        // bus-off flag refuses a clear until 128 recessive runs
        txErrCount <= 9'h100;
        bus(1, cif_pkg::IDX_RXFLG, 8'h04, 0);
        txErrCount <= 9'h000;
        recessiveRun <= 1'b1;
        repeat (127) @(posedge ref_clk);
        recessiveRun <= 1'b0;
        bus(1, cif_pkg::IDX_RXFLG, 8'h04, 0);
        bus(0, cif_pkg::IDX_RXFLG, rx_full_flag | 8'h86, 0);
        recessiveRun <= 1'b1;
        @(posedge ref_clk);
        recessiveRun <= 1'b0;
        bus(1, cif_pkg::IDX_RXFLG, 8'h04, 0);
        bus(0, cif_pkg::IDX_RXFLG, rx_full_flag | 8'h82, 0);
        $display("test bus-off done");
        bus(1, cif_pkg::IDX_MODCTL, 8'h01, 0);
        bus(1, cif_pkg::IDX_ACCCTL, 8'h20, 0);
        bus(1, cif_pkg::IDX_MODCTL, 8'h00, 0);
        bus(1, cif_pkg::IDX_RXIE, 8'h01, 0);
        // only filter five holds the low identifier byte
        acceptMask <= 64'h0;
        acceptCode <= 64'h7766_5544_3322_1100;
        rxIdent <= {24'($urandom), 8'h55};
        rxExtId <= 1'($urandom);
        rxMsgDone <= 1'b1;
        @(posedge ref_clk);
        rxMsgDone <= 1'b0;
        @(posedge ref_clk);
        `CHK("fgLoad", 1'b1, fgLoad)
        @(posedge ref_clk);
        `CHK("rxIrq", 1'b1, rxIrq)
        bus(0, cif_pkg::IDX_ACCCTL, 8'h25, 0);
        bus(0, cif_pkg::IDX_RXFLG, rx_full_flag | 8'h01, 0);
        $display("test acceptance done");
        repeat (2) @(posedge ref_clk);
        report_and_stop();
    end
endmodule : cif_ctrl_tb
